// [design/dsv_delay_rx.sv]
`timescale 1ns/10ps
module dsv_delay_rx (
  input  wire logic                                        pclk,
  input  wire logic                                        presetn,
  input  wire logic                                        ce,
  input  wire logic                                        src_alt,
  input  wire logic [1:0]                                  ser_data,
  input  wire logic [1:0]                                  ser_shift,
  input  wire logic [1:0]                                  ser_sync,
  output logic [dsv_pkg::DELAY_CNT-1:0][dsv_pkg::DELAY_W-1:0] delay_words,
  output logic                                             words_ready
);
  import dsv_pkg::*;

  dsv_rx_state_type q;
  dsv_rx_state_type d;
  logic             bit_in;
  logic             shift;
  logic             sync;

  ////////////////////////////////////////////////////////////////////////////
  // Source select, then shift in four words of sixteen bits
  always_comb begin
    bit_in = src_alt ? ser_data[1] : ser_data[0];
    shift  = src_alt ? ser_shift[1] : ser_shift[0];
    sync   = src_alt ? ser_sync[1] : ser_sync[0];
    d       = q;
    d.ready = 1'b0;
    if (sync) begin
      d.bit_cnt  = 4'h0;
      d.word_idx = 2'h0;
    end else if (shift) begin
      d.shreg   = {q.shreg[DELAY_W-2:0], bit_in};
      d.bit_cnt = q.bit_cnt + 4'h1;
      if (q.bit_cnt == 4'hF) begin
        d.words[q.word_idx] = {q.shreg[DELAY_W-2:0], bit_in};
        d.word_idx          = q.word_idx + 2'h1;
        d.ready             = (q.word_idx == 2'h3);
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign delay_words = q.words;
  assign words_ready = q.ready;

endmodule : dsv_delay_rx

// [design/dsv_pkg.sv]
package dsv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_SEQ_ADDR  = 12'h008;
  localparam logic [11:0] OFF_SEQ2_DATA = 12'h00C;
  localparam logic [11:0] OFF_SEQ3_DATA = 12'h010;
  localparam logic [11:0] OFF_SNAPSHOT  = 12'h014;
  localparam logic [11:0] OFF_DELAY0    = 12'h020;
  localparam logic [11:0] OFF_DELAY3    = 12'h02C;

  // Control register fields
  localparam int          CTRL_SRC_ALT    = 0;
  localparam int          CTRL_FORCE_INV  = 1;
  localparam int          CTRL_LOAD       = 2;
  localparam int          CTRL_ALT_VALID  = 3;
  localparam int          CTRL_HDR_PASS   = 4;
  localparam int          CTRL_SHORT_WR   = 5;
  localparam int          CTRL_OVL_LSB    = 8;
  localparam int          CTRL_INVCNT_LSB = 16;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK      = 32'h00FF_7F3F;

  // Sequencer 2 word layout
  localparam int S2_CAPTURE    = 1;
  localparam int S2_SHIFT_EN   = 2;
  localparam int S2_WCNT_EN_N  = 3;
  localparam int S2_STROBE_LSB = 4;

  // Sequencer 3 word layout
  localparam int S3_REWIND_LSB = 0;
  localparam int S3_DELAY_UPD  = 8;
  localparam int S3_OVL_CTRL_N = 11;

  // Sizes and limits
  localparam int         SEQ2_DEPTH   = 2048;
  localparam int         SEQ3_DEPTH   = 256;
  localparam int         SEQ3_W       = 12;
  localparam int         RD_ADDR_W    = 13;
  localparam int         DELAY_W      = 16;
  localparam int         DELAY_CNT    = 4;
  localparam logic [6:0] OVL_LIMIT    = 7'h20;
  localparam logic [1:0] HDR_FFT_HOLD = 2'h3;
  localparam logic       INACTIVE_N   = 1'b1;

  typedef struct packed {
    logic       capture;
    logic       shift_en;
    logic       wcnt_en_n;
    logic [3:0] strobes;
    logic       write_pulse;
  } dsv_seq2_out_type;

  typedef struct packed {
    logic quality_bad;
    logic servo_unavail;
    logic read_crosses_zero;
  } dsv_valid_src_type;

  typedef struct packed {
    logic [31:0]          ctrl;
    logic [10:0]          seq_addr;
    logic [10:0]          seq2_addr;
    dsv_seq2_out_type     seq2_out;
    logic [7:0]           seq3_addr;
    logic [SEQ3_W-1:0]    seq3_word;
    logic [7:0]           rewind_cnt;
    logic                 rewind_armed;
    logic [RD_ADDR_W-1:0] snapshot;
    logic                 snap_pulse;
    logic                 delay_update;
    logic                 overlap_ctrl_n;
    logic                 after_update;
    logic [7:0]           cycle_idx;
    logic [1:0]           hdr_hold;
    logic                 fft_valid;
    logic                 valid_strobe;
    logic                 header_pass;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } dsv_state_type;

  typedef struct packed {
    logic [DELAY_W-1:0]                shreg;
    logic [3:0]                        bit_cnt;
    logic [1:0]                        word_idx;
    logic [DELAY_CNT-1:0][DELAY_W-1:0] words;
    logic                              ready;
  } dsv_rx_state_type;

endpackage : dsv_pkg

// [design/dsv_seq_validity.sv]
// Operation
// - Sequencer 2 bit 1 strobes capture at the bit shuffler input.
// - Sequencer 2 bit 2 enables the shuffler serial shift register.
// - Sequencer 2 bit 3 is active-low enable of buffer write counter.
// - Sequencer 2 bits 4-7 are write strobes, combined into write pulse.
// - Sequencer 2 address runs 0 to 2047 and wraps.
// - Sequencer 2 address cleared by low delay-restart pulse each interval.
// - Sequencer 3 is 12 bits wide, address 0-255, one step per FFT.
// - Sequencer 3 low byte loads the rewind down counter.
// - Down counter at zero snapshots current read address for rewind.
// - Sequencer 3 bit 8 drives the delay-update pulse.
// - Sequencer 3 bits 9 and 10 are spare.
// - Sequencer 3 bit 11 low commands overlap control.
// - Four 16-bit delay words received serially every interval.
// - Delay words taken from normal or alternate source, host selected.
// - Every FFT cycle gets a valid or invalid flag.
// - Invalid on poor quality, servo, periodic, host force or header.
// - Mode sets 0 to 255 invalid cycles per interval.
// - Overlap below 32: read crossing address 0 after update is invalid.
// - Short-written buffer at overlap 32/64: update-to-fringe cycles invalid.
// - Data-replacing formats pass header bits through unchanged.
// - Alternate variant forces invalid at frame edge for three FFT pulses.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
module dsv_seq_validity (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              ce,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic [31:0]                            prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              rw_delay_restart_n,
  input  wire logic                              fft_cycle_pulse,
  input  wire logic                              frame_boundary,
  input  wire logic [dsv_pkg::RD_ADDR_W-1:0]     read_address,
  input  wire dsv_pkg::dsv_valid_src_type        valid_src,
  input  wire logic [1:0]                        ser_data,
  input  wire logic [1:0]                        ser_shift,
  input  wire logic [1:0]                        ser_sync,
  output dsv_pkg::dsv_seq2_out_type              seq2_out,
  output logic [dsv_pkg::RD_ADDR_W-1:0]          rewind_address,
  output logic                                   rewind_snap,
  output logic                                   delay_update,
  output logic                                   overlap_ctrl_n,
  output logic                                   fft_valid,
  output logic                                   fft_valid_strobe,
  output logic                                   header_passthrough
);
  import dsv_pkg::*;

  dsv_state_type                     q;
  dsv_state_type                     d;
  logic [7:0]                        seq2_ram [0:SEQ2_DEPTH-1];
  logic [SEQ3_W-1:0]                 seq3_ram [0:SEQ3_DEPTH-1];
  logic [DELAY_CNT-1:0][DELAY_W-1:0] delay_words;
  logic                              delay_ready;
  logic                              wr_take;
  logic                              load;
  logic [7:0]                        s2_word;
  logic [7:0]                        s3_next_addr;
  logic [SEQ3_W-1:0]                 s3_next_word;
  logic [6:0]                        ovl_factor;
  logic [7:0]                        inv_count;
  logic                              new_update;
  logic                              periodic_inv;
  logic                              overlap_inv;
  logic                              short_inv;
  logic                              hdr_force;

  ////////////////////////////////////////////////////////////////////////////
  // Serial delay word receiver
  dsv_delay_rx dsv_delay_rx_i (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .src_alt     (q.ctrl[CTRL_SRC_ALT]),
    .ser_data    (ser_data),
    .ser_shift   (ser_shift),
    .ser_sync    (ser_sync),
    .delay_words (delay_words),
    .words_ready (delay_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls and RAM lookups
  always_comb begin
    wr_take      = ce && psel && penable && pwrite && q.pready && !q.pslverr;
    load         = q.ctrl[CTRL_LOAD];
    ovl_factor   = q.ctrl[CTRL_OVL_LSB +: 7];
    inv_count    = q.ctrl[CTRL_INVCNT_LSB +: 8];
    s2_word      = seq2_ram[q.seq2_addr];
    s3_next_addr = q.seq3_addr + 8'h01;
    s3_next_word = seq3_ram[s3_next_addr];
    new_update   = s3_next_word[S3_DELAY_UPD];
    hdr_force    = q.ctrl[CTRL_ALT_VALID] && (q.hdr_hold != 2'h0);
    // Mode-dependent count of cycles after a delay update
    periodic_inv = q.after_update && (q.cycle_idx < inv_count);
    overlap_inv  = (ovl_factor < OVL_LIMIT) && q.after_update
                   && valid_src.read_crosses_zero;
    short_inv    = (ovl_factor >= OVL_LIMIT) && q.ctrl[CTRL_SHORT_WR]
                   && q.after_update;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    d              = q;
    d.pready       = 1'b0;
    d.pslverr      = 1'b0;
    d.snap_pulse   = 1'b0;
    d.valid_strobe = 1'b0;

    // APB setup phase: prepare answer for the access phase
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      if (paddr == OFF_CTRL) begin
        d.prdata = q.ctrl;
      end else if (paddr == OFF_STATUS) begin
        d.prdata = {q.seq2_addr, q.seq3_addr, 8'h00, 1'b0,
                    delay_ready, hdr_force, q.after_update, q.fft_valid};
      end else if (paddr == OFF_SEQ_ADDR) begin
        d.prdata = {21'h00_0000, q.seq_addr};
      end else if (paddr == OFF_SEQ2_DATA) begin
        d.prdata = {24'h00_0000, seq2_ram[q.seq_addr]};
      end else if (paddr == OFF_SEQ3_DATA) begin
        d.prdata = {20'h0_0000, seq3_ram[q.seq_addr[7:0]]};
      end else if (paddr == OFF_SNAPSHOT) begin
        d.prdata = {19'h0_0000, q.snapshot};
      end else if (paddr >= OFF_DELAY0 && paddr <= OFF_DELAY3
                   && paddr[1:0] == 2'h0) begin
        d.prdata = {16'h0000, delay_words[paddr[3:2]]};
      end else begin
        d.pslverr = 1'b1;
      end
    end

    // APB write at the completing edge
    if (wr_take) begin
      if (paddr == OFF_CTRL) begin
        d.ctrl = pwdata & CTRL_WMASK;
      end else if (paddr == OFF_SEQ_ADDR) begin
        d.seq_addr = pwdata[10:0];
      end else if (paddr == OFF_SEQ2_DATA || paddr == OFF_SEQ3_DATA) begin
        d.seq_addr = q.seq_addr + 11'h001;
      end
    end

    // Sequencer 2: free-running address, cleared by restart
    if (load) begin
      d.seq2_addr = 11'h000;
    end else if (!rw_delay_restart_n) begin
      d.seq2_addr = 11'h000;
    end else begin
      d.seq2_addr = q.seq2_addr + 11'h001;
    end
    // Word bit 0 is spare and not decoded
    d.seq2_out.capture     = s2_word[S2_CAPTURE];
    d.seq2_out.shift_en    = s2_word[S2_SHIFT_EN];
    d.seq2_out.wcnt_en_n   = s2_word[S2_WCNT_EN_N];
    d.seq2_out.strobes     = s2_word[S2_STROBE_LSB +: 4];
    d.seq2_out.write_pulse = |s2_word[S2_STROBE_LSB +: 4];

    // Sequencer 3: one step per FFT cycle
    if (load) begin
      d.seq3_addr    = 8'h00;
      d.rewind_armed = 1'b0;
      d.after_update = 1'b0;
    end else if (fft_cycle_pulse) begin
      d.seq3_addr      = s3_next_addr;
      d.seq3_word      = s3_next_word;
      d.rewind_cnt     = s3_next_word[S3_REWIND_LSB +: 8];
      d.rewind_armed   = 1'b1;
      d.delay_update   = new_update;
      d.overlap_ctrl_n = s3_next_word[S3_OVL_CTRL_N];
      // Bits 9 and 10 are spare and left undecoded
      if (s3_next_addr == 8'h00) begin
        d.after_update = 1'b0;
      end
      if (new_update) begin
        d.after_update = 1'b1;
        d.cycle_idx    = 8'h00;
      end else if (q.cycle_idx != 8'hFF) begin
        d.cycle_idx = q.cycle_idx + 8'h01;
      end
    end else if (q.rewind_armed) begin
      // Rewind point reached: keep the read address
      if (q.rewind_cnt == 8'h00) begin
        d.snapshot     = read_address;
        d.snap_pulse   = 1'b1;
        d.rewind_armed = 1'b0;
      end else begin
        d.rewind_cnt = q.rewind_cnt - 8'h01;
      end
    end

    // Header forcing: frame edge sets, FFT pulses count down
    if (frame_boundary && q.ctrl[CTRL_ALT_VALID]) begin
      d.hdr_hold = HDR_FFT_HOLD;
    end else if (fft_cycle_pulse && q.hdr_hold != 2'h0) begin
      d.hdr_hold = q.hdr_hold - 2'h1;
    end

    // Validity flag for each FFT cycle
    if (fft_cycle_pulse && !load) begin
      d.valid_strobe = 1'b1;
      d.fft_valid    = !(valid_src.quality_bad || valid_src.servo_unavail
                         || periodic_inv || overlap_inv || short_inv
                         || q.ctrl[CTRL_FORCE_INV] || hdr_force);
    end

    d.header_pass = q.ctrl[CTRL_HDR_PASS];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                    <= '0;
      q.ctrl               <= CTRL_RESET;
      q.seq2_out.wcnt_en_n <= INACTIVE_N;
      q.overlap_ctrl_n     <= INACTIVE_N;
    end else if (ce) begin
      q <= d;
    end
  end

  // Sequencer RAM loading, only in load mode
  always_ff @(posedge pclk) begin
    if (wr_take && load && paddr == OFF_SEQ2_DATA) begin
      seq2_ram[q.seq_addr] <= pwdata[7:0];
    end
    if (wr_take && load && paddr == OFF_SEQ3_DATA) begin
      seq3_ram[q.seq_addr[7:0]] <= pwdata[SEQ3_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign prdata             = q.prdata;
  assign pready             = q.pready;
  assign pslverr            = q.pslverr;
  assign seq2_out           = q.seq2_out;
  assign rewind_address     = q.snapshot;
  assign rewind_snap        = q.snap_pulse;
  assign delay_update       = q.delay_update;
  assign overlap_ctrl_n     = q.overlap_ctrl_n;
  assign fft_valid          = q.fft_valid;
  assign fft_valid_strobe   = q.valid_strobe;
  assign header_passthrough = q.header_pass;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    ce && psel && !penable;
  endsequence

  a_apb_ready_next: assert property (s_setup |=> pready)
    else $error("pready missing after setup");

  a_seq2_restart_clr: assert property (
    (ce && !load && !rw_delay_restart_n) |=> (q.seq2_addr == 11'h000))
    else $error("restart did not clear sequencer 2 address");

  a_seq2_addr_wrap: assert property (
    (ce && !load && rw_delay_restart_n && q.seq2_addr == 11'h7FF)
    |=> (q.seq2_addr == 11'h000))
    else $error("sequencer 2 address did not wrap");

  a_write_pulse_or: assert property (
    seq2_out.write_pulse |-> (seq2_out.strobes != 4'h0))
    else $error("write pulse without a strobe");

  a_write_pulse_hi: assert property (
    (seq2_out.strobes != 4'h0) |-> seq2_out.write_pulse)
    else $error("strobe without write pulse");

  a_seq3_step_one: assert property (
    (ce && !load && fft_cycle_pulse)
    |=> (q.seq3_addr == $past(q.seq3_addr) + 8'h01))
    else $error("sequencer 3 did not step once");

  a_rewind_snap_addr: assert property (
    (ce && q.rewind_armed && !fft_cycle_pulse && !load && q.rewind_cnt == 8'h00)
    |=> (rewind_snap && rewind_address == $past(read_address)))
    else $error("snapshot missing or wrong");

  a_force_invalid: assert property (
    (ce && !load && fft_cycle_pulse && q.ctrl[CTRL_FORCE_INV])
    |=> (fft_valid_strobe && !fft_valid))
    else $error("forced invalid not applied");

  a_load_hold_cnt: assert property (
    (ce && load) |=> (q.seq2_addr == 11'h000 && q.seq3_addr == 8'h00))
    else $error("counters moved during load");

  a_hdr_force_set: assert property (
    (ce && frame_boundary && q.ctrl[CTRL_ALT_VALID]) |=> (q.hdr_hold == 2'h3))
    else $error("header forcing not armed");

  sequence s_fft_step;
    ce && !load && fft_cycle_pulse;
  endsequence

  // Sequencer 3 step outputs and header forcing count
  a_valid_strobe_out: assert property (
    s_fft_step |=> fft_valid_strobe)
    else $error("validity strobe missing");

  a_update_bit_out: assert property (
    s_fft_step |=> (delay_update == $past(new_update)))
    else $error("delay update not from bit 8");

  a_overlap_bit_out: assert property (
    s_fft_step |=> (overlap_ctrl_n == $past(s3_next_word[S3_OVL_CTRL_N])))
    else $error("overlap control not from bit 11");

  a_hdr_count_down: assert property (
    (ce && fft_cycle_pulse && !frame_boundary && q.hdr_hold != 2'h0)
    |=> (q.hdr_hold == $past(q.hdr_hold) - 2'h1))
    else $error("header forcing count did not step");

  // Sequencer 2 bit decoding
  a_capture_bit_out: assert property (
    (ce && s2_word[S2_CAPTURE]) |=> seq2_out.capture)
    else $error("capture strobe not from bit 1");

  a_shift_bit_out: assert property (
    (ce && s2_word[S2_SHIFT_EN]) |=> seq2_out.shift_en)
    else $error("shift enable not from bit 2");

  a_wcnt_en_out: assert property (
    (ce && !s2_word[S2_WCNT_EN_N]) |=> !seq2_out.wcnt_en_n)
    else $error("write counter enable not from bit 3");

endmodule : dsv_seq_validity

// [tb/dsv_delay_src_model.sv]
`timescale 1ns/10ps
module dsv_delay_src_model (
  input  wire logic        pclk,
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [63:0] nwords,
  input  wire logic [63:0] awords,
  output logic      [1:0]  ser_data,
  output logic      [1:0]  ser_shift,
  output logic      [1:0]  ser_sync,
  output logic             busy
);
  // Idle lines at time zero
  initial begin
    ser_data  = 2'h0;
    ser_shift = 2'h0;
    ser_sync  = 2'h0;
    busy      = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Four words per group, word 0 first, MSB first, both sources at once
  always begin
    @(posedge pclk);
    if (start === 1'b1) begin
      busy     <= 1'b1;
      ser_sync <= 2'h3;
      @(posedge pclk);
      ser_sync <= 2'h0;
      for (int i = 63; i >= 0; i--) begin
        ser_data  <= {awords[i], nwords[i]};
        ser_shift <= 2'h3;
        @(posedge pclk);
        ser_shift <= 2'h0;
        ser_data  <= ~{awords[i], nwords[i]}; // No stale bit between strobes
        repeat (slow ? 3 : 1) @(posedge pclk);
      end
      busy <= 1'b0;
    end
  end
endmodule : dsv_delay_src_model

// [tb/dsv_seq_validity_tb.sv]
`timescale 1ns/10ps
module dsv_seq_validity_tb;
  import dsv_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic        err;
  } dsv_apb_note_type;
  localparam logic [7:0] S2V [3] = '{8'h01, 8'hA6, 8'h5A};
  logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                 pwrite = 1'b0, restart_n = 1'b1, fpulse = 1'b0, fedge = 1'b0;
  logic                 start = 1'b0, slow = 1'b0, pready, pslverr, busy, ce = 1'b1;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0000_0000, prdata, ctrl, v, rs = 32'h0000_f47c;
  logic [RD_ADDR_W-1:0] rd_addr = '0, rw_addr;
  dsv_valid_src_type    vsrc = '0;
  dsv_seq2_out_type     s2o;
  logic                 rw_snap, d_upd, ovl_n, f_valid, f_strobe, hdr_pass;
  logic [1:0]           sdata, sshift, ssync, vn;
  logic [63:0]          nw = '0, aw = '0;
  dsv_apb_note_type     note, aq[$];
  logic [1:0]           vq[$];
  int                   num_errors = 0, samples_checked = 0;

  always #4 pclk = ~pclk;

  dsv_seq_validity dsv_seq_validity_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rw_delay_restart_n(restart_n),
    .fft_cycle_pulse(fpulse), .frame_boundary(fedge), .read_address(rd_addr),
    .valid_src(vsrc), .ser_data(sdata), .ser_shift(sshift), .ser_sync(ssync),
    .seq2_out(s2o), .rewind_address(rw_addr), .rewind_snap(rw_snap),
    .delay_update(d_upd), .overlap_ctrl_n(ovl_n), .fft_valid(f_valid),
    .fft_valid_strobe(f_strobe), .header_passthrough(hdr_pass));
  dsv_delay_src_model dsv_delay_src_model_i (.pclk(pclk), .start(start), .slow(slow),
    .nwords(nw), .awords(aw), .ser_data(sdata), .ser_shift(sshift), .ser_sync(ssync),
    .busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // One APB transfer; the expected answer is noted first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic err);
    aq.push_back(dsv_apb_note_type'{d, m, err});
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr_ctrl(input logic [31:0] d);
    ctrl = d;
    apb(1'b1, OFF_CTRL, d, 32'h0000_0000, 1'b0);
  endtask : wr_ctrl

  // Fill one sequencer RAM in load mode, then read one word back
  task automatic load(input logic [11:0] a, input logic [31:0] d, input int cnt);
    wr_ctrl(32'h0000_0004);
    apb(1'b1, OFF_SEQ_ADDR, 32'h0000_0000, 32'h0000_0000, 1'b0);
    for (int i = 0; i < cnt; i++) apb(1'b1, a, d, 32'h0000_0000, 1'b0);
    apb(1'b1, OFF_SEQ_ADDR, 32'h0000_0007, 32'h0000_0000, 1'b0);
    apb(1'b0, a, d, 32'h0000_00FF, 1'b0);
  endtask : load

  // One FFT cycle with random sources; rewind timing checked after it
  task automatic fft(input logic care, input logic hdr, input logic after);
    logic [31:0] r;
    logic        bad;
    r = rnd();
    bad = r[2] | r[1] | ctrl[CTRL_FORCE_INV] | hdr
        | (after & (ctrl[14:8] < OVL_LIMIT) & r[0])
        | (after & (ctrl[14:8] >= OVL_LIMIT) & ctrl[CTRL_SHORT_WR]);
    vq.push_back({care, ~bad});
    vsrc    <= r[2:0];
    rd_addr <= r[31:19];
    fpulse  <= 1'b1;
    @(posedge pclk);
    fpulse <= 1'b0;
    repeat (5) @(posedge pclk);
    #1 check("rewind_snap", rw_snap, 0);
    @(posedge pclk);
    #1 check("rewind_snap", rw_snap, 1);
    check("rewind_address", rw_addr, rd_addr);
    repeat (3) @(posedge pclk);
  endtask : fft

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: oldest note against each answer
  always @(posedge pclk) begin
    if (pready === 1'b1 && aq.size() > 0) begin
      note = aq.pop_front();
      check("prdata", prdata & note.mask, note.data & note.mask);
      check("pslverr", pslverr, note.err);
    end
    if (f_strobe === 1'b1 && vq.size() > 0) begin
      vn = vq.pop_front();
      if (vn[1]) check("fft_valid", f_valid, vn[0]);
    end
  end

  // Watchdog
  initial begin
    #600_000;
    num_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (9) @(posedge pclk);
    #1 check("wcnt_en_n", s2o.wcnt_en_n, 1);
    check("overlap_ctrl_n", ovl_n, 1);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL, CTRL_RESET, 32'hFFFF_FFFF, 1'b0);
    v = rnd() & CTRL_WMASK & 32'hFF7F_FFFB;
    wr_ctrl(v);
    apb(1'b0, OFF_CTRL, v, 32'hFFFF_FFFF, 1'b0);
    check("header_passthrough", hdr_pass, v[CTRL_HDR_PASS]);
    wr_ctrl(32'h0000_0010);
    check("header_passthrough", hdr_pass, 1);
    apb(1'b0, 12'h0FC, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    for (int k = 0; k < 3; k++) begin
      load(OFF_SEQ2_DATA, {24'h00_0000, S2V[k]}, SEQ2_DEPTH);
      apb(1'b0, OFF_STATUS, 32'h0000_0000, 32'hFFE0_0000, 1'b0);
      wr_ctrl(32'h0000_0000);
      repeat (4) @(posedge pclk);
      check("seq2_out", s2o, {S2V[k][1], S2V[k][2], S2V[k][3], S2V[k][7:4],
                              |S2V[k][7:4]});
    end
    restart_n <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0000_0000, 32'hFFE0_0000, 1'b0);
    // Clock enable low: sequencer 2 address must not move
    restart_n <= 1'b1;
    ce        <= 1'b0;
    repeat (4) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, OFF_STATUS, 32'h0000_0000, 32'hFFE0_0000, 1'b0);
    load(OFF_SEQ3_DATA, 32'h0000_0805, SEQ3_DEPTH);
    wr_ctrl(32'h0000_0100);
    fft(1'b0, 1'b0, 1'b0);
    fft(1'b0, 1'b0, 1'b0);
    check("delay_update", d_upd, 0);
    check("overlap_ctrl_n", ovl_n, 1);
    for (int i = 0; i < 12; i++) begin
      if (i == 6) wr_ctrl(32'h0000_0102);
      fft(1'b1, 1'b0, 1'b0);
    end
    wr_ctrl(32'h0000_0108);
    fedge <= 1'b1;
    @(posedge pclk);
    fedge <= 1'b0;
    for (int i = 0; i < 4; i++) fft(1'b1, i < 3, 1'b0);
    load(OFF_SEQ3_DATA, 32'h0000_0105, SEQ3_DEPTH);
    wr_ctrl(32'h0000_0100);
    fft(1'b0, 1'b0, 1'b0);
    fft(1'b0, 1'b0, 1'b0);
    check("delay_update", d_upd, 1);
    check("overlap_ctrl_n", ovl_n, 0);
    for (int i = 0; i < 18; i++) begin
      if (i == 8) wr_ctrl(32'h0000_2020);
      if (i == 13) wr_ctrl(32'h0000_2000);
      fft(1'b1, 1'b0, 1'b1);
    end
    // One update word at address 3, two cycles invalid after it
    load(OFF_SEQ3_DATA, 32'h0000_0005, SEQ3_DEPTH);
    apb(1'b1, OFF_SEQ_ADDR, 32'h0000_0003, 32'h0000_0000, 1'b0);
    apb(1'b1, OFF_SEQ3_DATA, 32'h0000_0105, 32'h0000_0000, 1'b0);
    wr_ctrl(32'h0002_2000);
    for (int i = 0; i < 7; i++) fft(1'b1, i == 3 || i == 4, 1'b0);
    for (int s = 0; s < 2; s++) begin
      nw = {rnd(), rnd()};
      aw = {rnd(), rnd()};
      wr_ctrl(s);
      slow  <= s[0];
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      @(posedge pclk);
      while (busy === 1'b1) @(posedge pclk);
      for (int i = 0; i < 4; i++)
        apb(1'b0, OFF_DELAY0 + 12'(4 * i), {16'h0000, s ? aw[63 - 16 * i -: 16] :
            nw[63 - 16 * i -: 16]}, 32'h0000_FFFF, 1'b0);
    end
    repeat (4) @(posedge pclk);
    check("pending_notes", aq.size() + vq.size(), 0);
    test_done();
  end
endmodule : dsv_seq_validity_tb
